// ### rtl/ldc_pkg.sv
// Purpose: constants and carrier types for the lamp dimming input control
// Assumes: 100 MHz clk, synchronous active-low reset
// Notes: register offsets follow the coil/holding numbering of the Modbus map
package ldc_pkg;
  // timebase
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 10_000_000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_MS = TICK_PERIOD_NS / 1_000_000;
  localparam int LONG_PRESS_MS = 1000;
  localparam int LONG_TICKS = LONG_PRESS_MS / TICK_MS;
  localparam int STEP_MS = 500;
  localparam int STEP_TICKS = STEP_MS / TICK_MS;
  localparam int TMR_W = 8;

  // register offsets
  localparam logic [15:0] ADDR_POL = 16'h0109;
  localparam logic [15:0] ADDR_STYLE = 16'h010C;
  localparam logic [15:0] ADDR_SEL = 16'h010F;
  localparam logic [15:0] ADDR_OFFACT = 16'h00A0;
  localparam logic [15:0] ADDR_STATUS = 16'h0200;

  // reset values
  localparam logic RST_POL = 1'b0;
  localparam logic RST_STYLE = 1'b0;
  localparam logic RST_SEL = 1'b0;
  localparam logic [3:0] RST_OFFACT = 4'h0;
  localparam logic [3:0] RST_LEVEL = 4'hA;
  localparam logic RST_DIR_UP = 1'b0;

  // level range and off-action code
  localparam logic [3:0] LEVEL_MIN = 4'h1;
  localparam logic [3:0] LEVEL_MAX = 4'hA;
  localparam logic [3:0] OFFACT_RELAY_OFF = 4'h0;

  // status word fields
  localparam int ST_LEVEL_LSB = 0;
  localparam int ST_ON_BIT = 4;
  localparam int ST_DIR_BIT = 5;
  localparam int ST_ADJ_BIT = 6;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_PRESS = 2'b01,
    ST_ADJ = 2'b11,
    ST_FOLLOW = 2'b10
  } ldc_state_t;

  typedef struct packed
  {
    logic [2:0] lvl;
    logic [2:0] rise;
    logic [2:0] fall;
  } ldc_sw_t;

  typedef struct packed
  {
    logic pol;
    logic style;
    logic sel;
    logic [3:0] offact;
  } ldc_cfg_t;
endpackage

// ### rtl/ldc_in_cond.sv
// Purpose: synchronise the switch inputs, apply polarity, flag edges
// Assumes: raw inputs are asynchronous to clk
// Notes: two flip-flops before any logic reads a pin
`timescale 1ns/1ns
module ldc_in_cond
  import ldc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins and setting
  input wire logic [2:0] raw,
  input wire logic pol,
  // conditioned switches
  output ldc_sw_t sw_r
);
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] cur;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
    end
    else
    begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end

  // input 0 has no inversion option
  assign cur = s2_r ^ {pol, pol, 1'b0};

  always_ff @(posedge clk)
  begin
    if (!rstn)
      sw_r <= '0;
    else
    begin
      sw_r.lvl <= cur;
      sw_r.rise <= cur & ~sw_r.lvl;
      sw_r.fall <= ~cur & sw_r.lvl;
    end
  end

  ch0_plain_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(pol) |=> sw_r.rise[0] == 1'b0 || $past(s2_r[0]) && !$past(sw_r.lvl[0]))
    else $error("input 0 reacted to polarity");
endmodule

// ### rtl/ldc_top.sv
// Purpose: dimmer and on/off switch interpretation for a dimming ballast
// Assumes: configuration written through the Modbus register port
// Notes: one clock, tick-based timing shortened by parameters in simulation
`timescale 1ns/1ns
module ldc_top
  import ldc_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int LONG_T = LONG_TICKS,
  parameter int STEP_T = STEP_TICKS
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // wall switch pins
  input wire logic [2:0] switch_input_line,
  // register port from the Modbus engine
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_r,
  // lamp
  output logic lamp_on_r,
  output logic [3:0] level_r,
  output logic adjusting_r
);
  localparam int TW = $clog2(TICK_CYC + 1);

  ldc_sw_t sw;
  ldc_cfg_t cfg_r;
  ldc_state_t state_r;
  ldc_state_t state_nxt;
  logic [TW-1:0] tick_cnt_r;
  logic tick_r;
  logic [TMR_W-1:0] hold_r;
  logic [TMR_W-1:0] step_r;
  logic dir_up_r;
  logic [4:0] stepped;
  logic [15:0] rd_nxt;
  logic dim_lvl;
  logic dim_rise;
  logic dim_fall;
  logic long_hit;
  logic sw_on_ev;
  logic off_apply;
  logic ev_toggle;
  logic ev_dim_on;
  logic ev_dim_off;
  logic ev_adj_start;
  logic ev_step;
  logic dim_ev;

  // returns {dir_up, level} after one ramp step
  function automatic logic [4:0] step_fn(input logic [3:0] lv, input logic up);
    logic [3:0] n;
    logic u;
    n = lv;
    u = up;
    if (up && lv < LEVEL_MAX)
    begin
      n = lv + 4'h1;
      u = n != LEVEL_MAX;
    end
    else if (up)
    begin
      n = LEVEL_MAX - 4'h1;
      u = 1'b0;
    end
    else if (lv > LEVEL_MIN)
    begin
      n = lv - 4'h1;
      u = n == LEVEL_MIN;
    end
    else
    begin
      // off action can park the level at the floor while heading down
      n = LEVEL_MIN + 4'h1;
      u = 1'b1;
    end
    return {u, n};
  endfunction

  ldc_in_cond u_cond
  (
    .clk(clk),
    .rstn(rstn),
    .raw(switch_input_line),
    .pol(cfg_r.pol),
    .sw_r(sw)
  );

  // registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
      cfg_r <= '{pol: RST_POL, style: RST_STYLE, sel: RST_SEL, offact: RST_OFFACT};
    else if (reg_wr)
    begin
      case (reg_addr)
        ADDR_POL: cfg_r.pol <= reg_wdata[0];
        ADDR_STYLE: cfg_r.style <= reg_wdata[0];
        ADDR_SEL: cfg_r.sel <= reg_wdata[0];
        // out-of-range codes clamp to full brightness
        ADDR_OFFACT: cfg_r.offact <= (reg_wdata > 16'h000A) ? LEVEL_MAX : reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  always_comb
  begin
    rd_nxt = 16'h0000;
    case (reg_addr)
      ADDR_POL: rd_nxt[0] = cfg_r.pol;
      ADDR_STYLE: rd_nxt[0] = cfg_r.style;
      ADDR_SEL: rd_nxt[0] = cfg_r.sel;
      ADDR_OFFACT: rd_nxt[3:0] = cfg_r.offact;
      ADDR_STATUS:
      begin
        rd_nxt[ST_LEVEL_LSB +: 4] = level_r;
        rd_nxt[ST_ON_BIT] = lamp_on_r;
        rd_nxt[ST_DIR_BIT] = dir_up_r;
        rd_nxt[ST_ADJ_BIT] = adjusting_r;
      end
      default: rd_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      reg_rdata_r <= 16'h0000;
    else
      reg_rdata_r <= rd_nxt;
  end

  // free-running tick
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else if (tick_cnt_r == TW'(TICK_CYC - 1))
    begin
      tick_cnt_r <= '0;
      tick_r <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + TW'(1);
      tick_r <= 1'b0;
    end
  end

  // dimmer source and switch events
  assign dim_lvl = cfg_r.sel ? sw.lvl[2] : sw.lvl[0];
  assign dim_rise = cfg_r.sel ? sw.rise[2] : sw.rise[0];
  assign dim_fall = cfg_r.sel ? sw.fall[2] : sw.fall[0];
  assign sw_on_ev = cfg_r.sel ? sw.rise[1] : (sw.rise[1] | sw.rise[2]);
  // one switch falling while the other is still on does nothing
  assign off_apply = cfg_r.sel ? sw.fall[1] :
    ((sw.fall[1] && !sw.lvl[2]) || (sw.fall[2] && !sw.lvl[1]));
  assign long_hit = hold_r >= TMR_W'(LONG_T);

  // hold timer measures press time and off time, saturating
  always_ff @(posedge clk)
  begin
    if (!rstn)
      hold_r <= TMR_W'(LONG_T); // first toggle-on after reset is plain switching
    else if (dim_rise || dim_fall)
      hold_r <= '0;
    else if (tick_r && !long_hit)
      hold_r <= hold_r + TMR_W'(1);
  end

  // dimmer state machine
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (dim_rise)
          state_nxt = !cfg_r.style ? ST_PRESS : (long_hit ? ST_FOLLOW : ST_ADJ);
      ST_PRESS:
        if (dim_fall)
          state_nxt = ST_IDLE;
        else if (long_hit)
          state_nxt = ST_ADJ;
      ST_ADJ:
        if (dim_fall)
          state_nxt = ST_IDLE;
      ST_FOLLOW:
        if (dim_fall)
          state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_r <= ST_IDLE;
      adjusting_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      adjusting_r <= state_nxt == ST_ADJ;
    end
  end

  assign ev_toggle = !cfg_r.style && state_r == ST_PRESS && dim_fall;
  assign ev_dim_on = cfg_r.style && state_r == ST_IDLE && dim_rise;
  assign ev_dim_off = cfg_r.style && dim_fall && state_r != ST_IDLE;
  assign ev_adj_start = state_nxt == ST_ADJ && state_r != ST_ADJ;
  assign ev_step = state_r == ST_ADJ && !dim_fall && tick_r && step_r == TMR_W'(STEP_T - 1);
  assign dim_ev = ev_toggle | ev_dim_on | ev_dim_off | ev_adj_start | ev_step;
  assign stepped = step_fn(level_r, dir_up_r);

  // ramp rate counter
  always_ff @(posedge clk)
  begin
    if (!rstn)
      step_r <= '0;
    else if (state_r != ST_ADJ || ev_step)
      step_r <= '0;
    else if (tick_r)
      step_r <= step_r + TMR_W'(1);
  end

  // lamp: switch events are applied last and win over the dimmer
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      lamp_on_r <= 1'b0;
      level_r <= RST_LEVEL;
      dir_up_r <= RST_DIR_UP;
    end
    else
    begin
      if (ev_toggle)
        lamp_on_r <= !lamp_on_r;
      if (ev_dim_on || ev_adj_start)
        lamp_on_r <= 1'b1;
      if (ev_dim_off)
        lamp_on_r <= 1'b0;
      if (ev_step)
      begin
        // level and direction are kept on release for the next ramp
        {dir_up_r, level_r} <= stepped;
      end
      if (sw_on_ev)
        lamp_on_r <= 1'b1;
      if (off_apply)
      begin
        lamp_on_r <= cfg_r.offact != OFFACT_RELAY_OFF;
        if (cfg_r.offact != OFFACT_RELAY_OFF)
          level_r <= cfg_r.offact;
      end
    end
  end

  ch2_ignores_ch0_a: assert property (@(posedge clk) disable iff (!rstn)
    cfg_r.sel && state_r == ST_IDLE && sw.rise[0] && !sw.rise[2] |=> state_r == ST_IDLE)
    else $error("input 0 acted as dimmer");
  pb_short_a: assert property (@(posedge clk) disable iff (!rstn)
    ev_toggle && !sw_on_ev && !off_apply |=> lamp_on_r != $past(lamp_on_r))
    else $error("short press did not toggle");
  pb_long_a: assert property (@(posedge clk) disable iff (!rstn)
    !cfg_r.style && state_r == ST_PRESS && long_hit && !dim_fall |=> adjusting_r)
    else $error("long press did not start ramp");
  ramp_stop_a: assert property (@(posedge clk) disable iff (!rstn)
    state_r == ST_ADJ && dim_fall && !off_apply |=> !adjusting_r && $stable(level_r))
    else $error("release did not stop ramp");
  ramp_cycle_a: assert property (@(posedge clk) disable iff (!rstn)
    ev_step && level_r == LEVEL_MAX && !off_apply |=> level_r == LEVEL_MAX - 4'h1 && !dir_up_r)
    else $error("ramp did not turn at top");
  restore_on_a: assert property (@(posedge clk) disable iff (!rstn)
    sw_on_ev && !off_apply && !ev_step |=> lamp_on_r && $stable(level_r))
    else $error("switch on did not restore level");
  off_action_a: assert property (@(posedge clk) disable iff (!rstn)
    off_apply |=> lamp_on_r == ($past(cfg_r.offact) != OFFACT_RELAY_OFF))
    else $error("off action not applied");
  other_on_keep_a: assert property (@(posedge clk) disable iff (!rstn)
    !cfg_r.sel && sw.fall[1] && sw.lvl[2] && !sw.rise[1] && !sw.rise[2] && !dim_ev
    |=> $stable(lamp_on_r) && $stable(level_r))
    else $error("lamp changed while other switch on");
  tg_follow_a: assert property (@(posedge clk) disable iff (!rstn)
    cfg_r.style && state_r == ST_IDLE && dim_rise && long_hit && !off_apply
    |=> lamp_on_r && !adjusting_r)
    else $error("toggle on did not light");
  tg_short_off_a: assert property (@(posedge clk) disable iff (!rstn)
    cfg_r.style && state_r == ST_IDLE && dim_rise && !long_hit |=> adjusting_r)
    else $error("short off did not start ramp");
  step_rate_a: assert property (@(posedge clk) disable iff (!rstn)
    state_r == ST_ADJ && !ev_step && !off_apply |=> $stable(level_r))
    else $error("level moved outside a step");

  pb_ramp_c: cover property (@(posedge clk) disable iff (!rstn) !cfg_r.style && ev_step);
  tg_ramp_c: cover property (@(posedge clk) disable iff (!rstn) cfg_r.style && ev_step);
  toggle_c: cover property (@(posedge clk) disable iff (!rstn) ev_toggle);
  off_act_c: cover property (@(posedge clk) disable iff (!rstn) off_apply && cfg_r.offact != 4'h0);
endmodule

// ### testbench/ldc_switch_model.sv
// Purpose: behavioural wall switches wired to the three input pins
// Assumes: callers enter the tasks 1 ns after a rising clock edge
// Notes: every pin is always driven, a switch never leaves its line floating
`timescale 1ns/1ns
module ldc_switch_model
(
  // clock
  input wire logic clk,
  // switch pins, high = contact closed
  output logic [2:0] pin
);
  initial pin = 3'h0;

  task automatic set(input int ch, input logic v);
    pin[ch] = v;
  endtask

  // keeps the 1 ns phase so callers stay off the sampling edge
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic press(input int ch, input int n);
    set(ch, 1'b1);
    hold(n);
    set(ch, 1'b0);
  endtask
endmodule

// ### testbench/tb.sv
// Purpose: self-checking bench for the lamp dimming input control
// Assumes: shortened timing, 10 clocks a tick, long press 10 ticks, step 4 ticks
// Notes: ramp levels are predicted step by step, so tick phase does not matter
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR t=%0t mismatch got %0h exp %0h", $time, a, b); end end
module tb
  import ldc_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] pins;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] rdata;
  logic [15:0] a_rand;
  logic [15:0] reg_rdata_r;
  logic lamp_on_r;
  logic adjusting_r;
  logic adj_q;
  logic [3:0] level_r;
  logic [3:0] prev_lvl;
  logic [3:0] offact;
  logic [3:0] m_lvl = 4'hA;
  logic m_up = 1'b0;
  logic exp_on = 1'b0;
  int err_total = 0;
  int check_count = 0;
  int n;
  int holds[3] = '{300, 420, 520};

  always #5 clk = ~clk;

  ldc_switch_model ldc_switch_model_i (.clk(clk), .pin(pins));

  ldc_top #(.TICK_CYC(10), .LONG_T(10), .STEP_T(4)) ldc_top_i
  (
    .clk(clk),
    .rstn(rstn),
    .switch_input_line(pins),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r),
    .lamp_on_r(lamp_on_r),
    .level_r(level_r),
    .adjusting_r(adjusting_r)
  );

  // ramp model: every level change while adjusting must be the next cyclic step
  always @(posedge clk)
  begin
    adj_q <= adjusting_r;
    prev_lvl <= level_r;
    if (rstn && (adjusting_r || adj_q) && level_r != prev_lvl)
    begin
      if (m_up && m_lvl == LEVEL_MAX)
        m_up = 1'b0;
      else if (!m_up && m_lvl == LEVEL_MIN)
        m_up = 1'b1;
      m_lvl = m_up ? m_lvl + 4'h1 : m_lvl - 4'h1;
      `CHK(level_r, m_lvl)
    end
  end

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    reg_addr = a;
    @(posedge clk);
    #1 d = reg_rdata_r;
  endtask

  task automatic wrc(input logic [15:0] a, input logic [15:0] d, input logic [15:0] e);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    rd(a, rdata);
    `CHK(rdata, e)
  endtask

  task automatic look();
    `CHK(lamp_on_r, exp_on)
    `CHK(level_r, m_lvl)
  endtask

  // pin change, then wait past the 4-clock input path
  task automatic ev(input int ch, input logic v);
    ldc_switch_model_i.set(ch, v);
    ldc_switch_model_i.hold(8);
  endtask

  task automatic offa();
    exp_on = (offact != 4'h0);
    if (offact != 4'h0)
      m_lvl = offact;
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    err_total++;
    tally_and_finish();
  end

  initial
  begin
    void'($urandom(74));
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    rd(ADDR_STATUS, rdata);
    `CHK(rdata, 16'h000A)
    foreach (holds[i])
    begin
      rd(i == 0 ? ADDR_POL : i == 1 ? ADDR_SEL : ADDR_OFFACT, rdata);
      `CHK(rdata, 16'h0000)
    end
    wrc(ADDR_STYLE, 16'hFFFF, 16'h0001);
    wrc(ADDR_STYLE, 16'h0000, 16'h0000);
    wrc(ADDR_OFFACT, 16'h000B + 16'($urandom % 5), 16'h000A);
    wrc(16'h0123, 16'h0055, 16'h0000);
    offact = 4'(1 + $urandom % 10);
    wrc(ADDR_OFFACT, {12'h000, offact}, {12'h000, offact});
    // random unmapped writes must leave every setting alone
    repeat (8)
    begin
      a_rand = 16'($urandom);
      if (a_rand inside {ADDR_POL, ADDR_STYLE, ADDR_SEL, ADDR_OFFACT, ADDR_STATUS})
        a_rand = a_rand ^ 16'h8000;
      wrc(a_rand, 16'($urandom), 16'h0000);
    end
    rd(ADDR_OFFACT, rdata);
    `CHK(rdata, {12'h000, offact})
    rd(ADDR_STYLE, rdata);
    `CHK(rdata, 16'h0000)
    rd(ADDR_SEL, rdata);
    `CHK(rdata, 16'h0000)
    rd(ADDR_POL, rdata);
    `CHK(rdata, 16'h0000)
    done("registers");
    // long holds: reverses at 10% and at 100%, resumes from the stop level
    foreach (holds[i])
    begin
      ldc_switch_model_i.set(0, 1'b1);
      ldc_switch_model_i.hold(holds[i]);
      exp_on = 1'b1;
      `CHK(adjusting_r, 1'b1)
      ev(0, 1'b0);
      `CHK(adjusting_r, 1'b0)
      look();
    end
    ldc_switch_model_i.hold(100);
    look();
    repeat (2)
    begin
      n = 5 + $urandom % 60;
      ldc_switch_model_i.press(0, n);
      ldc_switch_model_i.hold(8);
      exp_on = ~exp_on;
      look();
    end
    done("push button");
    ev(1, 1'b1);
    exp_on = 1'b1;
    look();
    ev(2, 1'b1);
    ev(1, 1'b0);
    look();
    ev(2, 1'b0);
    offa();
    look();
    ev(2, 1'b1);
    exp_on = 1'b1;
    look();
    ev(2, 1'b0);
    done("on off switches");
    wrc(ADDR_SEL, 16'h0001, 16'h0001);
    ldc_switch_model_i.press(0, 30);
    ldc_switch_model_i.hold(8);
    look();
    ldc_switch_model_i.press(2, 5 + $urandom % 60);
    ldc_switch_model_i.hold(8);
    exp_on = ~exp_on;
    look();
    ev(1, 1'b1);
    exp_on = 1'b1;
    look();
    ev(1, 1'b0);
    offa();
    look();
    wrc(ADDR_SEL, 16'h0000, 16'h0000);
    done("dimmer on input 2");
    wrc(ADDR_STYLE, 16'h0001, 16'h0001);
    ldc_switch_model_i.hold(150);
    ev(0, 1'b1);
    exp_on = 1'b1;
    look();
    `CHK(adjusting_r, 1'b0)
    ev(0, 1'b0);
    exp_on = 1'b0;
    look();
    ldc_switch_model_i.hold(150);
    ev(0, 1'b1);
    exp_on = 1'b1;
    `CHK(adjusting_r, 1'b0)
    repeat (2)
    begin
      ev(0, 1'b0);
      exp_on = 1'b0;
      look();
      `CHK(adjusting_r, 1'b0)
      ldc_switch_model_i.hold(20);
      ldc_switch_model_i.set(0, 1'b1);
      ldc_switch_model_i.hold(200);
      exp_on = 1'b1;
      `CHK(adjusting_r, 1'b1)
    end
    ev(0, 1'b0);
    exp_on = 1'b0;
    look();
    done("toggle");
    wrc(ADDR_STYLE, 16'h0000, 16'h0000);
    offact = 4'h0;
    wrc(ADDR_OFFACT, 16'h0000, 16'h0000);
    // inverted lines idle low, so both on/off switches read as closed
    wrc(ADDR_POL, 16'h0001, 16'h0001);
    ldc_switch_model_i.hold(8);
    exp_on = 1'b1;
    look();
    ev(1, 1'b1);
    look();
    ev(2, 1'b1);
    offa();
    look();
    ldc_switch_model_i.press(0, 5 + $urandom % 60);
    ldc_switch_model_i.hold(8);
    exp_on = ~exp_on;
    look();
    rd(ADDR_STATUS, rdata);
    // direction bit shows where the next step goes, turning at the end stops
    `CHK(rdata, {10'h000, (m_lvl == LEVEL_MAX) ? 1'b0 : (m_lvl == LEVEL_MIN) ? 1'b1 : m_up, exp_on, m_lvl})
    done("polarity");
    tally_and_finish();
  end
endmodule
